// ===== common/sink_sel_pkg.sv
// Shared types and constants for the sink select sideband controller.
// Assumes a single 20 MHz clock domain and asynchronous sink pin inputs.
package sink_sel_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned SWITCH_HPD_US = 100;
  localparam int unsigned SWITCH_HPD_CYC =
    (SWITCH_HPD_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SYNC_STAGES  = 2;

  // Three-level strap codes
  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } level_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_DP   = 2'h1,
    SEL_TMDS = 2'h2
  } sink_sel_t;

  localparam logic [6:0] CTRL_ADDR_MID  = 7'h2C;
  localparam logic [6:0] CTRL_ADDR_HIGH = 7'h2D;
  localparam logic [1:0] PRE_0DB        = 2'h0;
  localparam logic [1:0] PRE_2DB        = 2'h1;
  localparam logic [1:0] PRE_INVALID    = 2'h3;

  // Link training levels snooped from the AUX channel
  typedef struct packed {
    logic       valid;
    logic [1:0] swing;
    logic [1:0] preemph;
    logic [1:0] eq;
  } train_req_t;

  // Configuration handed to the analog front end
  typedef struct packed {
    logic       ctrl_enable;
    logic [6:0] ctrl_addr;
    logic [1:0] tmds_slew;
    logic [1:0] ddc_thresh;
    logic       dvi_mode;
    logic [1:0] tmds_preemph;
    logic [1:0] in_eq;
    logic [1:0] dp_swing;
    logic [1:0] dp_preemph;
  } fe_cfg_t;

endpackage

// ===== rtl/level_sync.sv
// Two-flop synchroniser for a bundle of single-bit levels.
// Assumes nothing about the inputs beyond being levels.
module level_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;

  if (WIDTH < 1) begin : g_width_check
    $error("level_sync: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      o_sync  <= '0;
    end else begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end

endmodule

// ===== rtl/sink_select_sideband_ctrl.sv
// Sink selection and sideband control for a one-in two-out display switch.
// Assumes the straps are pre-decoded to three-level codes and that the
// local control port registers arrive as plain ports.
//
// How it works
// - Source hotplug high while a sink selected
// - Hold source hotplug during priority switch
// - DP: adapter detect follows sink, optional invert
// - TMDS sink: adapter detect driven high
// - DP: adapter level picks DP or TMDS
// - Both present: priority picks the sink
// - TMDS sink: type input picks HDMI/DVI
// - Slew strap picks TMDS edge class
// - DDC strap picks source threshold set
// - Enable strap disables or addresses control
// - Clock pin is EQ when control off
// - AUX passes through only for DP
// - ID buffer readable over DDC for TMDS
// - No main link activity: outputs off
// - No sink connected: standby
// - Snooped training sets swing, emphasis, EQ
// - Test mode: software owns source and DP sink hotplug
// - Data pin sets TMDS emphasis if off
// - Enable low resets config, outputs off
module sink_select_sideband_ctrl #(
  parameter int unsigned HOLD_CYC = sink_sel_pkg::SWITCH_HPD_CYC
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_enable,
  // Sink side hot plug and adapter detect
  input  wire logic                  i_dp_sink_hotplug_in,
  input  wire logic                  i_tmds_sink_hotplug_in,
  input  wire logic                  i_sink_adapter_detect_in,
  input  wire logic                  i_priority,
  // Straps, already resolved to three-level codes
  input  wire sink_sel_pkg::level_t  i_local_ctrl_enable_addr_strap,
  input  wire sink_sel_pkg::level_t  i_ctrl_clock_or_eq_pin,
  input  wire sink_sel_pkg::level_t  i_ctrl_data_or_preemph_pin,
  input  wire sink_sel_pkg::level_t  i_tmds_slew_select,
  input  wire sink_sel_pkg::level_t  i_ddc_buffer_select,
  input  wire logic                  i_sink_type_dvi,
  // Local control settings
  input  wire logic                  i_adapter_invert,
  input  wire logic                  i_test_mode,
  input  wire logic                  i_test_source_hotplug,
  input  wire logic                  i_test_dp_sink_hotplug,
  input  wire logic [1:0]            i_ctrl_eq,
  // Main link and AUX snoop
  input  wire logic                  i_main_link_active,
  input  wire sink_sel_pkg::train_req_t i_train_req,
  // Outputs
  output logic                       o_source_hotplug_out,
  output logic                       o_source_adapter_detect_out,
  output sink_sel_pkg::sink_sel_t    o_sink_sel,
  output logic                       o_tmds_signalling,
  output logic                       o_aux_connect,
  output logic                       o_ddc_id_enable,
  output logic                       o_output_disable,
  output logic                       o_standby,
  output logic                       o_ctrl_clock_en,
  output sink_sel_pkg::fe_cfg_t      o_fe_cfg
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks and types

  localparam int unsigned CW = $clog2(HOLD_CYC + 1);

  if (HOLD_CYC < 1) begin : g_hold_check
    $error("HOLD_CYC must be at least one");
  end

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_SWITCH = 2'h2
  } state_t;

  function automatic logic [1:0] slew_class(sink_sel_pkg::level_t lv);
    case (lv)
      sink_sel_pkg::LVL_LOW:  slew_class = 2'h1;
      sink_sel_pkg::LVL_HIGH: slew_class = 2'h3;
      default:                slew_class = 2'h2;
    endcase
  endfunction

  function automatic logic [1:0] ddc_set(sink_sel_pkg::level_t lv);
    case (lv)
      sink_sel_pkg::LVL_LOW:  ddc_set = 2'h3;
      sink_sel_pkg::LVL_HIGH: ddc_set = 2'h1;
      default:                ddc_set = 2'h2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [2:0] raw_in;
  logic [2:0] sync_in;
  logic       dp_hp;
  logic       tmds_hp;
  logic       adapt;
  logic       prio_ff;

  assign raw_in = {i_dp_sink_hotplug_in, i_tmds_sink_hotplug_in,
                   i_sink_adapter_detect_in};

  level_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (raw_in),
    .o_sync  (sync_in)
  );

  // Priority is a quasi-static strap; two register stages suffice
  logic prio_meta_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prio_meta_ff <= 1'b0;
      prio_ff      <= 1'b0;
    end else begin
      prio_meta_ff <= i_priority;
      prio_ff      <= prio_meta_ff;
    end
  end

  // Test mode overrides the DP sink hot plug from software
  assign dp_hp   = i_test_mode ? i_test_dp_sink_hotplug : sync_in[2];
  assign tmds_hp = sync_in[1];
  assign adapt   = sync_in[0];

  ////////////////////////////////////////////////////////////////////////
  // Sink selection

  sink_sel_pkg::sink_sel_t want_sel;
  always_comb begin
    if (dp_hp && tmds_hp) begin
      want_sel = prio_ff ? sink_sel_pkg::SEL_TMDS
                         : sink_sel_pkg::SEL_DP;
    end else if (dp_hp) begin
      want_sel = sink_sel_pkg::SEL_DP;
    end else if (tmds_hp) begin
      want_sel = sink_sel_pkg::SEL_TMDS;
    end else begin
      want_sel = sink_sel_pkg::SEL_NONE;
    end
  end

  state_t                  state_ff;
  state_t                  nxt_state;
  sink_sel_pkg::sink_sel_t sel_ff;
  sink_sel_pkg::sink_sel_t nxt_sel;
  logic [CW-1:0]           hold_ff;
  logic [CW-1:0]           nxt_hold;

  // Switch between live sinks keeps hotplug high for the hold time
  always_comb begin
    nxt_state = state_ff;
    nxt_sel   = sel_ff;
    nxt_hold  = hold_ff;
    case (state_ff)
      ST_IDLE: begin
        if (want_sel != sink_sel_pkg::SEL_NONE) begin
          nxt_state = ST_ACTIVE;
          nxt_sel   = want_sel;
        end
      end
      ST_ACTIVE: begin
        if (want_sel == sink_sel_pkg::SEL_NONE) begin
          nxt_state = ST_IDLE;
          nxt_sel   = sink_sel_pkg::SEL_NONE;
        end else if (want_sel != sel_ff) begin
          nxt_state = ST_SWITCH;
          nxt_sel   = want_sel;
          nxt_hold  = CW'(HOLD_CYC - 1);
        end
      end
      ST_SWITCH: begin
        if (want_sel == sink_sel_pkg::SEL_NONE) begin
          nxt_state = ST_IDLE;
          nxt_sel   = sink_sel_pkg::SEL_NONE;
          nxt_hold  = '0;
        end else if (hold_ff == '0) begin
          nxt_state = ST_ACTIVE;
          nxt_sel   = want_sel;
        end else begin
          nxt_hold  = hold_ff - CW'(1);
          nxt_sel   = want_sel;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_sel   = sink_sel_pkg::SEL_NONE;
        nxt_hold  = '0;
      end
    endcase
  end

  // Power down returns selection to idle as well
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      sel_ff   <= sink_sel_pkg::SEL_NONE;
      hold_ff  <= '0;
    end else if (!i_enable) begin
      state_ff <= ST_IDLE;
      sel_ff   <= sink_sel_pkg::SEL_NONE;
      hold_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      sel_ff   <= nxt_sel;
      hold_ff  <= nxt_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hot plug and adapter detect toward the source

  logic ctrl_on;
  logic sel_dp;
  logic sel_tmds;
  assign ctrl_on = (i_local_ctrl_enable_addr_strap != sink_sel_pkg::LVL_LOW);
  assign sel_dp   = (nxt_sel == sink_sel_pkg::SEL_DP);
  assign sel_tmds = (nxt_sel == sink_sel_pkg::SEL_TMDS);

  // These two stay alive through power down; hotplug then follows sink presence, adapter detect the selection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_source_hotplug_out <= 1'b0;
    end else if (i_test_mode) begin
      o_source_hotplug_out <= i_test_source_hotplug;
    end else if (i_enable) begin
      o_source_hotplug_out <= (nxt_state != ST_IDLE);
    end else begin
      o_source_hotplug_out <= dp_hp || tmds_hp;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_source_adapter_detect_out <= 1'b0;
    end else if (sel_tmds) begin
      o_source_adapter_detect_out <= 1'b1;
    end else if (sel_dp) begin
      o_source_adapter_detect_out <= adapt ^
        (i_adapter_invert && i_enable && ctrl_on);
    end else begin
      o_source_adapter_detect_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing and power state

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sink_sel        <= sink_sel_pkg::SEL_NONE;
      o_tmds_signalling <= 1'b0;
      o_aux_connect     <= 1'b0;
      o_ddc_id_enable   <= 1'b0;
      o_output_disable  <= 1'b1;
      o_standby         <= 1'b1;
      o_ctrl_clock_en   <= 1'b0;
    end else begin
      o_sink_sel        <= nxt_sel;
      o_tmds_signalling <= sel_tmds || (sel_dp && adapt);
      o_aux_connect     <= i_enable && sel_dp;
      o_ddc_id_enable   <= i_enable && sel_tmds;
      o_output_disable  <= !i_enable || !i_main_link_active;
      o_standby         <= !dp_hp && !tmds_hp;
      o_ctrl_clock_en   <= i_enable && ctrl_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Front end configuration

  // Snooped training levels persist until the next training request seen with DP selected, or enable low
  sink_sel_pkg::train_req_t train_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      train_ff <= '0;
    end else if (!i_enable) begin
      train_ff <= '0;
    end else if (i_train_req.valid && sel_dp) begin
      train_ff <= i_train_req;
    end
  end

  sink_sel_pkg::fe_cfg_t nxt_cfg;
  always_comb begin
    nxt_cfg             = '0;
    nxt_cfg.ctrl_enable = ctrl_on;
    case (i_local_ctrl_enable_addr_strap)
      sink_sel_pkg::LVL_MID:  nxt_cfg.ctrl_addr = sink_sel_pkg::CTRL_ADDR_MID;
      sink_sel_pkg::LVL_HIGH: nxt_cfg.ctrl_addr = sink_sel_pkg::CTRL_ADDR_HIGH;
      default:                nxt_cfg.ctrl_addr = '0;
    endcase
    nxt_cfg.dvi_mode   = sel_tmds && i_sink_type_dvi;
    // Slew and DDC threshold only matter on the TMDS sink path
    if (sel_tmds) begin
      nxt_cfg.tmds_slew  = slew_class(i_tmds_slew_select);
      nxt_cfg.ddc_thresh = ddc_set(i_ddc_buffer_select);
    end
    if (!ctrl_on) begin
      nxt_cfg.in_eq = i_ctrl_clock_or_eq_pin;
      if (sel_tmds) begin
        case (i_ctrl_data_or_preemph_pin)
          sink_sel_pkg::LVL_LOW:  nxt_cfg.tmds_preemph = sink_sel_pkg::PRE_0DB;
          sink_sel_pkg::LVL_HIGH: nxt_cfg.tmds_preemph = sink_sel_pkg::PRE_2DB;
          default: nxt_cfg.tmds_preemph = sink_sel_pkg::PRE_INVALID;
        endcase
      end
    end else begin
      nxt_cfg.in_eq = i_ctrl_eq;
    end
    if (train_ff.valid) begin
      nxt_cfg.in_eq      = train_ff.eq;
      nxt_cfg.dp_swing   = train_ff.swing;
      nxt_cfg.dp_preemph = train_ff.preemph;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fe_cfg <= '0;
    end else if (!i_enable) begin
      o_fe_cfg <= '0;
    end else begin
      o_fe_cfg <= nxt_cfg;
    end
  end

endmodule

// ===== bench/sink_sel_props.sv
// Concurrent checks on the sink select sideband controller ports.
// Assumes one clock domain and the async active-high reset.
module sink_sel_props #(
  parameter int unsigned HOLD_CYC = 4
) (
  // Clock, reset and controls
  input wire logic                      i_clk,
  input wire logic                      i_rst,
  input wire logic                      i_enable,
  input wire logic                      i_sink_adapter_detect_in,
  input wire logic                      i_adapter_invert,
  input wire logic                      i_test_mode,
  input wire sink_sel_pkg::level_t      i_local_ctrl_enable_addr_strap,
  input wire sink_sel_pkg::train_req_t  i_train_req,
  // Watched outputs
  input wire logic                      o_source_hotplug_out,
  input wire logic                      o_source_adapter_detect_out,
  input wire sink_sel_pkg::sink_sel_t   o_sink_sel,
  input wire logic                      o_aux_connect,
  input wire logic                      o_ddc_id_enable,
  input wire logic                      o_ctrl_clock_en,
  input wire sink_sel_pkg::fe_cfg_t     o_fe_cfg
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs reflect the enable seen one edge earlier
  logic live_ff, norm_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      live_ff <= 1'b0;
      norm_ff <= 1'b0;
    end else begin
      live_ff <= i_enable;
      norm_ff <= i_enable & ~i_test_mode;
    end
  end
  sequence s_dp_steady;
    (live_ff && o_sink_sel == sink_sel_pkg::SEL_DP
      && $stable(i_sink_adapter_detect_in) && $stable(i_adapter_invert)) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_hpd_tracks_sel: assert property (
    norm_ff |-> o_source_hotplug_out == (o_sink_sel != sink_sel_pkg::SEL_NONE))
    else $error("source hotplug disagrees with selection");
  a_switch_hpd_held: assert property (
    norm_ff && $past(o_sink_sel) == sink_sel_pkg::SEL_DP
      && o_sink_sel == sink_sel_pkg::SEL_TMDS |-> o_source_hotplug_out)
    else $error("hotplug dropped during sink switch");
  a_dp_adp_follow: assert property (
    s_dp_steady |-> o_source_adapter_detect_out ==
      (i_sink_adapter_detect_in ^ (i_adapter_invert & o_fe_cfg.ctrl_enable)))
    else $error("adapter detect does not follow sink");
  a_tmds_adp_high: assert property (
    live_ff && o_sink_sel == sink_sel_pkg::SEL_TMDS
      |-> o_source_adapter_detect_out)
    else $error("adapter detect low with tmds sink");
  a_addr_strap: assert property (
    live_ff && $past(i_local_ctrl_enable_addr_strap) != sink_sel_pkg::LVL_LOW
      |-> o_fe_cfg.ctrl_enable && o_fe_cfg.ctrl_addr ==
      ($past(i_local_ctrl_enable_addr_strap) == sink_sel_pkg::LVL_HIGH
        ? sink_sel_pkg::CTRL_ADDR_HIGH : sink_sel_pkg::CTRL_ADDR_MID))
    else $error("control address wrong for strap");
  a_clk_pin_role: assert property (
    live_ff |-> o_ctrl_clock_en ==
      ($past(i_local_ctrl_enable_addr_strap) != sink_sel_pkg::LVL_LOW))
    else $error("clock pin role wrong for strap");
  a_aux_dp_only: assert property (
    live_ff |-> o_aux_connect == (o_sink_sel == sink_sel_pkg::SEL_DP))
    else $error("aux path state disagrees with selection");
  a_ddc_id_tmds: assert property (
    live_ff |-> o_ddc_id_enable == (o_sink_sel == sink_sel_pkg::SEL_TMDS))
    else $error("id buffer state disagrees with selection");
  a_train_apply: assert property (
    (live_ff && i_enable && i_train_req.valid
      && o_sink_sel == sink_sel_pkg::SEL_DP
      ##1 i_enable && o_sink_sel == sink_sel_pkg::SEL_DP)
      |-> ##1 o_fe_cfg.dp_swing == $past(i_train_req.swing, 2)
        && o_fe_cfg.dp_preemph == $past(i_train_req.preemph, 2))
    else $error("snooped training levels not applied");
  c_dp_sel: cover property (o_sink_sel == sink_sel_pkg::SEL_DP);
  c_tmds_sel: cover property (o_sink_sel == sink_sel_pkg::SEL_TMDS);
  c_switch: cover property ($past(o_sink_sel) == sink_sel_pkg::SEL_DP
    && o_sink_sel == sink_sel_pkg::SEL_TMDS);
endmodule
bind sink_select_sideband_ctrl sink_sel_props #(.HOLD_CYC(HOLD_CYC)) props_u (
  .i_clk, .i_rst, .i_enable, .i_sink_adapter_detect_in, .i_adapter_invert,
  .i_test_mode, .i_local_ctrl_enable_addr_strap, .i_train_req,
  .o_source_hotplug_out, .o_source_adapter_detect_out, .o_sink_sel,
  .o_aux_connect, .o_ddc_id_enable, .o_ctrl_clock_en, .o_fe_cfg);

// ===== bench/sink_pair_model.sv
// Behavioural pair of display sinks on the switch's sink side.
// Assumes the bench commands presence; hotplug pins carry pull-downs.
module sink_pair_model (
  // Presence commands
  input  wire logic i_dp_present,
  input  wire logic i_tmds_present,
  input  wire logic i_dp_cable_tmds,
  // Sink pins
  output logic      o_dp_hotplug,
  output logic      o_tmds_hotplug,
  output logic      o_adapter
);
  timeunit 1ns;
  timeprecision 1ns;
  // Absent sink drives the pin low itself, never a stale level
  assign o_dp_hotplug = i_dp_present;
  assign o_tmds_hotplug = i_tmds_present;
  // Adapter level only exists while the cable is plugged
  assign o_adapter = i_dp_present & i_dp_cable_tmds;
endmodule

// ===== bench/test_sink_select_sideband_ctrl.sv
// Self-checking bench for the sink select sideband controller.
// Assumes the sink pair model and the checker are compiled first.
module test_sink_select_sideband_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst, i_enable, dp_on, tmds_on, cab_tmds, i_priority;
  logic dvi, inv, tmode, t_hpd, act, dp_hp, tmds_hp, adp;
  logic hpd, adp_out, tmds_sig, aux, ddc_id, odis, stby, clk_en;
  sink_sel_pkg::level_t       strap, pre_pin, slew, ddc, eqp;
  sink_sel_pkg::train_req_t   train;
  sink_sel_pkg::sink_sel_t    sel;
  sink_sel_pkg::fe_cfg_t      cfg;
  int                         fails, tests_run;
  sink_pair_model sinks_u (.i_dp_present(dp_on), .i_tmds_present(tmds_on),
    .i_dp_cable_tmds(cab_tmds), .o_dp_hotplug(dp_hp),
    .o_tmds_hotplug(tmds_hp), .o_adapter(adp));
  // Short hold keeps the switch window visible in a brief run
  sink_select_sideband_ctrl #(.HOLD_CYC(4)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_enable(i_enable),
    .i_dp_sink_hotplug_in(dp_hp), .i_tmds_sink_hotplug_in(tmds_hp),
    .i_sink_adapter_detect_in(adp), .i_priority(i_priority),
    .i_local_ctrl_enable_addr_strap(strap),
    .i_ctrl_clock_or_eq_pin(eqp),
    .i_ctrl_data_or_preemph_pin(pre_pin), .i_tmds_slew_select(slew),
    .i_ddc_buffer_select(ddc), .i_sink_type_dvi(dvi),
    .i_adapter_invert(inv), .i_test_mode(tmode),
    .i_test_source_hotplug(t_hpd), .i_test_dp_sink_hotplug(1'b0),
    .i_ctrl_eq(2'h0), .i_main_link_active(act), .i_train_req(train),
    .o_source_hotplug_out(hpd), .o_source_adapter_detect_out(adp_out),
    .o_sink_sel(sel), .o_tmds_signalling(tmds_sig), .o_aux_connect(aux),
    .o_ddc_id_enable(ddc_id), .o_output_disable(odis), .o_standby(stby),
    .o_ctrl_clock_en(clk_en), .o_fe_cfg(cfg));
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask
  task automatic chk_f(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_f({6'h0, got}, {6'h0, exp});
  endtask
  task automatic chk_sel(input sink_sel_pkg::sink_sel_t exp);
    chk_f({5'h0, sel}, {5'h0, exp});
  endtask
  task automatic finish_test();
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Whole run is about 75 cycles; the limit leaves a wide margin
  initial begin
    #50000;
    fails++;
    finish_test();
  end
  initial begin
    i_rst = 1'b1;
    i_enable = 1'b1;
    {dp_on, tmds_on, cab_tmds, i_priority} = 4'h0;
    {dvi, inv, tmode, t_hpd, act} = 5'h1;
    strap = sink_sel_pkg::LVL_MID;
    pre_pin = sink_sel_pkg::LVL_LOW;
    slew = sink_sel_pkg::LVL_MID;
    ddc = sink_sel_pkg::LVL_MID;
    eqp = sink_sel_pkg::LVL_HIGH;
    train = '0;
    fails = 0;
    tests_run = 0;
    step(4);
    i_rst = 1'b0;
    step(4);
    chk_b(hpd, 1'b0);
    chk_b(stby, 1'b1);
    dp_on = 1'b1;
    step(4);
    chk_sel(sink_sel_pkg::SEL_DP);
    chk_b(hpd, 1'b1);
    chk_b(aux, 1'b1);
    chk_b(adp_out, 1'b0);
    chk_b(tmds_sig, 1'b0);
    cab_tmds = 1'b1;
    step(4);
    chk_b(adp_out, 1'b1);
    chk_b(tmds_sig, 1'b1);
    inv = 1'b1;
    step(4);
    chk_b(adp_out, 1'b0);
    inv = 1'b0;
    train = {1'b1, 2'h2, 2'h3, 2'h1};
    step(1);
    train.valid = 1'b0;
    step(2);
    chk_f({3'h0, cfg.dp_swing, cfg.dp_preemph}, 7'hB);
    chk_f({5'h0, cfg.in_eq}, 7'h1);
    i_enable = 1'b0;
    step(2);
    i_enable = 1'b1;
    step(4);
    chk_f({3'h0, cfg.dp_swing, cfg.dp_preemph}, 7'h0);
    tmds_on = 1'b1;
    step(4);
    chk_sel(sink_sel_pkg::SEL_DP);
    i_priority = 1'b1;
    step(4);
    chk_sel(sink_sel_pkg::SEL_TMDS);
    chk_b(hpd, 1'b1);
    chk_b(adp_out, 1'b1);
    chk_b(ddc_id, 1'b1);
    chk_b(aux, 1'b0);
    dp_on = 1'b0;
    for (int i = 0; i < 3; i++) begin
      slew = sink_sel_pkg::level_t'(i);
      ddc = sink_sel_pkg::level_t'(i);
      dvi = i[0];
      step(4);
      chk_f({5'h0, cfg.tmds_slew}, 7'(i + 1));
      chk_f({5'h0, cfg.ddc_thresh}, 7'(3 - i));
      chk_b(cfg.dvi_mode, i[0]);
      chk_b(adp_out, 1'b1);
    end
    for (int i = 2; i >= 0; i--) begin
      strap = sink_sel_pkg::level_t'(i);
      step(2);
      chk_b(clk_en, i != 0);
      chk_b(cfg.ctrl_enable, i != 0);
      chk_f({5'h0, cfg.in_eq}, (i == 0) ? 7'h2 : 7'h0);
      if (i != 0) chk_f(cfg.ctrl_addr, 7'h2B + 7'(i));
    end
    pre_pin = sink_sel_pkg::LVL_HIGH;
    step(2);
    chk_f({5'h0, cfg.tmds_preemph}, {5'h0, sink_sel_pkg::PRE_2DB});
    pre_pin = sink_sel_pkg::LVL_LOW;
    step(2);
    chk_f({5'h0, cfg.tmds_preemph}, {5'h0, sink_sel_pkg::PRE_0DB});
    act = 1'b0;
    step(4);
    chk_b(odis, 1'b1);
    act = 1'b1;
    step(4);
    chk_b(odis, 1'b0);
    {tmode, t_hpd} = 2'h2;
    step(2);
    chk_b(hpd, 1'b0);
    tmode = 1'b0;
    step(2);
    chk_b(hpd, 1'b1);
    tmds_on = 1'b0;
    step(4);
    chk_sel(sink_sel_pkg::SEL_NONE);
    chk_b(hpd, 1'b0);
    chk_b(stby, 1'b1);
    finish_test();
  end
endmodule
